// ---- pdm_dev.sv ----
/*
  power-down mode controller: clock division, sleep, software and hardware standby,
  module stop gating. assumes the host end drives pins and cpu events synchronously.
*/
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "pdm_regs.svh"
module pdm_dev #(
  parameter int N = 8,                          // module count, bit 0 = transfer controller
  parameter logic [7:0] LOSE_MASK = 8'he0,      // modules whose state is lost when stopped
  parameter int SETTLE_BASE = 256               // settle cycles for select 0, doubled per step
) (
  input wire logic sys_clk_i,   // system clock
  input wire logic rst_n_i,     // synchronous reset, active low
  pdm_if.dev lnk                // link to host end
);
  if (N < 2 || N > 16) begin : g_chk_n
    $error("pdm_dev: N out of range");
  end
  if (SETTLE_BASE < 1 || SETTLE_BASE > 1024) begin : g_chk_base
    $error("pdm_dev: SETTLE_BASE out of range");
  end

  // ==================================================
  // state
  pdm_pkg::pdm_mode_e mode_q, mode_d;
  pdm_pkg::pdm_data_t ctrl_q, ctrl_d;
  logic [N-1:0] halt_q, halt_d;
  logic [N-1:0] mstop_q, mstop_d;
  logic [15:0] irq_en_q, irq_en_d;
  logic [2:0] act_div_q, act_div_d;
  logic [4:0] div_cnt_q, div_cnt_d;
  logic [17:0] settle_q, settle_d;
  logic int_exc_q, int_exc_d;
  logic rst_exc_q, rst_exc_d;
  pdm_pkg::pdm_data_t rdata_q, rdata_d;

  logic [N-1:0] halt_rst;
  logic [2:0] sel_div;
  logic [4:0] div_len;
  logic div_tick;
  logic sleep_wake;
  logic standby_pin_n_wake;
  logic [17:0] settle_len;
  logic in_reset;

  assign halt_rst = {{(N-1){1'b1}}, 1'b0};
  assign sel_div = ctrl_q[`PDM_F_DIV_HI:`PDM_F_DIV_LO];
  assign div_len = 5'((6'h01 << act_div_q) - 6'h01);
  assign div_tick = (div_cnt_q == div_len);
  assign sleep_wake = lnk.nmi | (lnk.int_pend & ~lnk.int_mask);
  assign standby_pin_n_wake = lnk.nmi | ((|(lnk.irq & irq_en_q)) & ~lnk.int_mask);
  assign settle_len = 18'(SETTLE_BASE) << ctrl_q[`PDM_F_STS_HI:`PDM_F_STS_LO];
  assign in_reset = (mode_q == pdm_pkg::PDM_RESET) || (mode_q == pdm_pkg::PDM_HWSTBY);

  // ==================================================
  // operating mode
  always_comb begin
    mode_d = mode_q;
    settle_d = settle_q;
    int_exc_d = 1'b0;
    rst_exc_d = 1'b0;
    if (!lnk.standby_pin_n) begin
      mode_d = pdm_pkg::PDM_HWSTBY;
    end else if (!lnk.reset_pin_n || lnk.wdt_ovf) begin
      mode_d = pdm_pkg::PDM_RESET;
    end else begin
      unique case (mode_q)
        pdm_pkg::PDM_HWSTBY: begin
          mode_d = pdm_pkg::PDM_RESET;
        end
        pdm_pkg::PDM_RESET: begin
          mode_d = pdm_pkg::PDM_RUN;
          rst_exc_d = 1'b1;
        end
        pdm_pkg::PDM_RUN: begin
          if (lnk.sleep_exec) begin
            if (!ctrl_q[`PDM_F_SOFTWARE_STANDBY_SELECT]) begin
              mode_d = pdm_pkg::PDM_SLEEP;
            end else if (!ctrl_q[`PDM_F_PSS]) begin
              mode_d = pdm_pkg::PDM_SWSTBY;
            end
          end
        end
        pdm_pkg::PDM_SLEEP: begin
          if (sleep_wake) begin
            mode_d = pdm_pkg::PDM_RUN;
            int_exc_d = 1'b1;
          end
        end
        pdm_pkg::PDM_SWSTBY: begin
          settle_d = '0;
          if (standby_pin_n_wake) begin
            mode_d = pdm_pkg::PDM_SETTLE;
          end
        end
        pdm_pkg::PDM_SETTLE: begin
          settle_d = settle_q + 18'h00001;
          if (settle_q >= settle_len - 18'h00001) begin
            mode_d = pdm_pkg::PDM_RUN;
            int_exc_d = 1'b1;
          end
        end
        default: begin
          mode_d = pdm_pkg::PDM_RESET;
        end
      endcase
    end
    if (!rst_n_i) begin
      mode_d = pdm_pkg::PDM_RESET;
      settle_d = '0;
      int_exc_d = 1'b0;
      rst_exc_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    mode_q <= mode_d;
    settle_q <= settle_d;
    int_exc_q <= int_exc_d;
    rst_exc_q <= rst_exc_d;
  end

  // ==================================================
  // registers and bus slave
  always_comb begin
    ctrl_d = ctrl_q;
    halt_d = halt_q;
    irq_en_d = irq_en_q;
    rdata_d = rdata_q;
    if (lnk.wr) begin
      unique case (lnk.addr)
        `PDM_OFS_STANDBY_PIN_N_CTRL: ctrl_d = lnk.wdata;
        `PDM_OFS_HALT: begin
          halt_d = lnk.wdata[N-1:0];
          // a coincident bus request keeps the controller running; software retries
          if (lnk.dtc_req) begin
            halt_d[0] = halt_q[0];
          end
        end
        `PDM_OFS_IRQ_EN: irq_en_d = lnk.wdata;
        default: ;
      endcase
    end
    if (lnk.rd) begin
      unique case (lnk.addr)
        `PDM_OFS_STANDBY_PIN_N_CTRL: rdata_d = ctrl_q;
        `PDM_OFS_HALT: rdata_d = 16'(halt_q);
        `PDM_OFS_IRQ_EN: rdata_d = irq_en_q;
        `PDM_OFS_STATUS: rdata_d = {10'h000, mode_q};
        default: rdata_d = '0;
      endcase
    end
    // every reset and hardware standby restores defaults, which also drops medium speed
    if (!rst_n_i || in_reset) begin
      ctrl_d = `PDM_STANDBY_PIN_N_RST;
      halt_d = halt_rst;
      irq_en_d = '0;
      rdata_d = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    ctrl_q <= ctrl_d;
    halt_q <= halt_d;
    irq_en_q <= irq_en_d;
    rdata_q <= rdata_d;
  end

  // ==================================================
  // speed and module stop, both applied at a bus cycle boundary
  always_comb begin
    act_div_d = act_div_q;
    mstop_d = mstop_q;
    div_cnt_d = div_tick ? 5'h00 : div_cnt_q + 5'h01;
    if (lnk.bus_end) begin
      act_div_d = (sel_div > `PDM_DIV_MAX) ? `PDM_DIV_MAX : sel_div;
      mstop_d = halt_q;
      // restart only on a new ratio, so a boundary held high keeps the divider counting
      if (act_div_d != act_div_q) begin
        div_cnt_d = 5'h00;
      end
    end
    if (!rst_n_i || in_reset) begin
      act_div_d = 3'h0;
      mstop_d = halt_rst;
      div_cnt_d = 5'h00;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    act_div_q <= act_div_d;
    mstop_q <= mstop_d;
    div_cnt_q <= div_cnt_d;
  end

  // ==================================================
  // outputs
  logic running;
  assign running = (mode_q == pdm_pkg::PDM_RUN);
  assign lnk.cpu_tick = running & div_tick;
  assign lnk.dtc_tick = (running | (mode_q == pdm_pkg::PDM_SLEEP)) & ~mstop_q[0] &
                        (ctrl_q[`PDM_F_FULL] | div_tick);
  assign lnk.per_tick = running | (mode_q == pdm_pkg::PDM_SLEEP);
  assign lnk.osc_run = (mode_q != pdm_pkg::PDM_SWSTBY) & (mode_q != pdm_pkg::PDM_HWSTBY);
  assign lnk.chip_reset = in_reset;
  assign lnk.io_hiz = (mode_q == pdm_pkg::PDM_HWSTBY);
  assign lnk.int_exc = int_exc_q;
  assign lnk.rst_exc = rst_exc_q;
  assign lnk.mstop = mstop_q;
  assign lnk.rdata = rdata_q;
  assign lnk.ram_en = ctrl_q[`PDM_F_RAM_ENABLE_BIT];
  assign lnk.sub_en = ctrl_q[`PDM_F_SUBEN];
  assign lnk.mode = mode_q;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_mod
      // stopped or standby modules in the lossy set are cleared, the rest hold
      assign lnk.mclear[g] = LOSE_MASK[g % 8] &
                             (mstop_q[g] | (mode_q == pdm_pkg::PDM_SWSTBY));
      assign lnk.per_acc_en[g] = lnk.per_sel[g] & ~mstop_q[g];
    end
  endgenerate
endmodule : pdm_dev

// ---- pdm_host.sv ----
/*
  outside party of the power-down controller: drives the reset and standby pins with
  the settling wait, issues sleep and watchdog events, forwards register accesses.
  assumes a plain register port from software and cpu event inputs.
*/
`timescale 1ns/100ps
`include "pdm_regs.svh"
module pdm_host #(
  parameter int N = 8,                        // module count
  parameter int SETTLE_CYC = `PDM_SETTLE_CYC  // oscillator settling in cycles
) (
  input wire logic sys_clk_i,                 // system clock
  input wire logic rst_n_i,                   // synchronous reset, active low
  input wire pdm_pkg::pdm_addr_t usr_addr_i,  // register address
  input wire pdm_pkg::pdm_data_t usr_wdata_i, // write data
  input wire logic usr_wr_i,                  // write strobe
  input wire logic usr_rd_i,                  // read strobe
  output pdm_pkg::pdm_data_t usr_rdata_o,     // read data, cycle after strobe
  input wire logic bus_end_i,                 // cpu bus cycle ends
  input wire logic dtc_req_i,                 // transfer controller bus request
  input wire logic nmi_i,                     // nonmaskable interrupt
  input wire logic [15:0] irq_i,              // external interrupt lines
  input wire logic int_pend_i,                // accepted-ready interrupt pending
  input wire logic int_mask_i,                // cpu masks maskable interrupts
  input wire logic [N-1:0] per_sel_i,         // peripheral register select
  output logic [1:0] mode_pins_o,             // mode select pins two and one
  pdm_if.host lnk                             // link to device end
);
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_chk_settle
    $error("pdm_host: SETTLE_CYC out of range");
  end

  // ==================================================
  // state
  logic [4:0] hctrl_q, hctrl_d;
  logic [1:0] mode_q, mode_d;
  logic [15:0] settle_q, settle_d;
  logic [1:0] sub_q, sub_d;
  logic sleep_q, sleep_d;
  logic wdt_q, wdt_d;
  logic dev_rd_q, dev_rd_d;
  pdm_pkg::pdm_data_t rdata_q, rdata_d;
  logic dev_hit;
  logic sub_ready;

  assign dev_hit = (usr_addr_i <= `PDM_DEV_TOP);
  assign sub_ready = (sub_q == 2'(`PDM_SUB_WAIT_CYC));

  always_comb begin
    hctrl_d = hctrl_q;
    mode_d = mode_q;
    sleep_d = 1'b0;
    wdt_d = 1'b0;
    rdata_d = rdata_q;
    dev_rd_d = 1'b0;
    settle_d = settle_q;
    sub_d = sub_q;
    if (usr_wr_i && usr_addr_i == `PDM_OFS_HCTRL) begin
      hctrl_d = usr_wdata_i[4:0];
      // power-down only after the subclock has loaded long enough
      sleep_d = usr_wdata_i[`PDM_H_SLEEP] & (sub_ready | ~hctrl_q[`PDM_H_SUBEN]);
      wdt_d = usr_wdata_i[`PDM_H_WDT];
    end
    if (usr_wr_i && usr_addr_i == `PDM_OFS_HMODE && lnk.standby_pin_n) begin
      mode_d = usr_wdata_i[1:0];
    end
    if (!hctrl_q[`PDM_H_SUBEN]) begin
      sub_d = 2'h0;
    end else if (!sub_ready) begin
      sub_d = sub_q + 2'h1;
    end
    // reset pin stays low while asked and for the settling time after standby or reset
    if (hctrl_q[`PDM_H_RESET] || hctrl_q[`PDM_H_STANDBY_PIN_N]) begin
      settle_d = 16'(SETTLE_CYC);
    end else if (settle_q != 16'h0000) begin
      settle_d = settle_q - 16'h0001;
    end
    if (usr_rd_i) begin
      dev_rd_d = dev_hit;
      unique case (usr_addr_i)
        `PDM_OFS_HCTRL: rdata_d = {11'h000, hctrl_q};
        `PDM_OFS_HMODE: rdata_d = {14'h0000, mode_q};
        `PDM_OFS_HSTAT: rdata_d = {13'h0000, lnk.io_hiz, lnk.chip_reset, lnk.osc_run};
        default: rdata_d = '0;
      endcase
    end
    if (!rst_n_i) begin
      hctrl_d = `PDM_HCTRL_RST;
      mode_d = 2'h0;
      sleep_d = 1'b0;
      wdt_d = 1'b0;
      rdata_d = '0;
      dev_rd_d = 1'b0;
      settle_d = 16'(SETTLE_CYC);
      sub_d = 2'h0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    hctrl_q <= hctrl_d;
    mode_q <= mode_d;
    sleep_q <= sleep_d;
    wdt_q <= wdt_d;
    rdata_q <= rdata_d;
    dev_rd_q <= dev_rd_d;
    settle_q <= settle_d;
    sub_q <= sub_d;
  end

  // ==================================================
  // link drive
  assign lnk.standby_pin_n = ~hctrl_q[`PDM_H_STANDBY_PIN_N];
  assign lnk.reset_pin_n = (settle_q == 16'h0000);
  assign lnk.sleep_exec = sleep_q;
  assign lnk.wdt_ovf = wdt_q;
  assign lnk.bus_end = bus_end_i;
  assign lnk.dtc_req = dtc_req_i;
  assign lnk.nmi = nmi_i;
  assign lnk.irq = irq_i;
  assign lnk.int_pend = int_pend_i;
  assign lnk.int_mask = int_mask_i;
  assign lnk.per_sel = per_sel_i;
  assign lnk.addr = usr_addr_i;
  assign lnk.wdata = usr_wdata_i;
  assign lnk.wr = usr_wr_i & dev_hit;
  assign lnk.rd = usr_rd_i & dev_hit;
  assign usr_rdata_o = dev_rd_q ? lnk.rdata : rdata_q;
  assign mode_pins_o = mode_q;
endmodule : pdm_host

// ---- pdm_if.sv ----
/*
  link between the power-down controller (dev) and the cpu/pin side (host).
  assumes both ends on the same system clock.
*/
`timescale 1ns/100ps
interface pdm_if #(parameter int N = 8);
  logic reset_pin_n;
  logic standby_pin_n;
  logic sleep_exec;
  logic bus_end;
  logic wdt_ovf;
  logic nmi;
  logic [15:0] irq;
  logic int_pend;
  logic int_mask;
  logic dtc_req;
  logic [N-1:0] per_sel;
  pdm_pkg::pdm_addr_t addr;
  pdm_pkg::pdm_data_t wdata;
  logic wr;
  logic rd;
  pdm_pkg::pdm_data_t rdata;
  logic cpu_tick;
  logic dtc_tick;
  logic per_tick;
  logic osc_run;
  logic chip_reset;
  logic io_hiz;
  logic int_exc;
  logic rst_exc;
  logic [N-1:0] mstop;
  logic [N-1:0] mclear;
  logic [N-1:0] per_acc_en;
  logic ram_en;
  logic sub_en;
  pdm_pkg::pdm_mode_e mode;
  modport dev (
    input reset_pin_n, standby_pin_n, sleep_exec, bus_end, wdt_ovf, nmi, irq, int_pend,
    input int_mask, dtc_req, per_sel, addr, wdata, wr, rd,
    output rdata, cpu_tick, dtc_tick, per_tick, osc_run, chip_reset, io_hiz, int_exc,
    output rst_exc, mstop, mclear, per_acc_en, ram_en, sub_en, mode
  );
  modport host (
    output reset_pin_n, standby_pin_n, sleep_exec, bus_end, wdt_ovf, nmi, irq, int_pend,
    output int_mask, dtc_req, per_sel, addr, wdata, wr, rd,
    input rdata, cpu_tick, dtc_tick, per_tick, osc_run, chip_reset, io_hiz, int_exc,
    input rst_exc, mstop, mclear, per_acc_en, ram_en, sub_en, mode
  );
endinterface : pdm_if

// ---- pdm_pkg.sv ----
/*
  types of the power-down mode controller.
  assumes pdm_regs.svh for the numbers.
*/
package pdm_pkg;
  typedef enum logic [5:0] {
    PDM_RESET = 6'h01,
    PDM_RUN = 6'h02,
    PDM_SLEEP = 6'h04,
    PDM_SWSTBY = 6'h08,
    PDM_SETTLE = 6'h10,
    PDM_HWSTBY = 6'h20
  } pdm_mode_e;
  typedef logic [15:0] pdm_data_t;
  typedef logic [7:0] pdm_addr_t;
endpackage : pdm_pkg

// ---- pdm_props.sv ----
/*
  checker of the power-down link: mode changes, wakes and gating.
  assumes the signals of one pdm_if instance on one system clock.
*/
`timescale 1ns/100ps
module pdm_props #(
  parameter int N = 8 // module count
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic reset_pin_n, // reset pin
  input wire logic standby_pin_n, // standby pin
  input wire logic wdt_ovf, // watchdog overflow
  input wire logic nmi, // nonmaskable line
  input wire logic int_pend, // interrupt pending
  input wire logic int_mask, // cpu mask
  input wire logic [N-1:0] per_sel, // register select
  input wire logic [N-1:0] mstop, // module halted
  input wire logic [N-1:0] per_acc_en, // access allowed
  input wire logic cpu_tick, // cpu state strobe
  input wire logic per_tick, // peripheral clock
  input wire logic osc_run, // oscillator on
  input wire logic chip_reset, // chip in reset
  input wire logic io_hiz, // ports floating
  input wire logic int_exc, // interrupt handling
  input wire logic rst_exc, // reset handling
  input wire pdm_pkg::pdm_mode_e mode // current mode
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic pins_up;
  // wakes only count when no pin or watchdog cause outranks them
  assign pins_up = reset_pin_n && standby_pin_n && !wdt_ovf;
  // ==================================================
  // assertions
  a_standby_pin_n_pin_wins: assert property (!standby_pin_n |=> mode == pdm_pkg::PDM_HWSTBY)
    else $error("standby pin did not enter hardware standby");
  a_reset_pin_cancel: assert property (standby_pin_n && (!reset_pin_n || wdt_ovf)
    |=> mode == pdm_pkg::PDM_RESET) else $error("reset cause ignored");
  a_sleep_wake_int: assert property (pins_up && mode == pdm_pkg::PDM_SLEEP &&
    (nmi || (int_pend && !int_mask)) |=> int_exc && mode == pdm_pkg::PDM_RUN)
    else $error("sleep not left on interrupt");
  a_sleep_masked_stay: assert property (pins_up && mode == pdm_pkg::PDM_SLEEP &&
    !nmi && !(int_pend && !int_mask) |=> mode == pdm_pkg::PDM_SLEEP)
    else $error("sleep left without interrupt");
  a_sleep_cpu_halt: assert property (mode == pdm_pkg::PDM_SLEEP |-> !cpu_tick && per_tick)
    else $error("sleep clocks wrong");
  a_swstby_all_stop: assert property (mode == pdm_pkg::PDM_SWSTBY
    |-> !osc_run && !cpu_tick && !per_tick) else $error("software standby clocks running");
  a_swstby_wake: assert property (pins_up && mode == pdm_pkg::PDM_SWSTBY && nmi
    |=> mode == pdm_pkg::PDM_SETTLE) else $error("standby wake missed");
  a_hwstby_float: assert property (mode == pdm_pkg::PDM_HWSTBY |-> io_hiz && chip_reset)
    else $error("hardware standby ports not floating");
  a_reset_osc_on: assert property (mode == pdm_pkg::PDM_RESET |-> osc_run && chip_reset)
    else $error("reset without clock");
  a_halt_gates_acc: assert property (per_acc_en == (per_sel & ~mstop))
    else $error("halted module reachable");
  a_reset_exit_exc: assert property (pins_up && mode == pdm_pkg::PDM_RESET
    |=> rst_exc && mode == pdm_pkg::PDM_RUN) else $error("reset exit wrong");
  a_reset_halts_all: assert property (rst_exc |-> mstop == {{(N-1){1'b1}}, 1'b0})
    else $error("modules not halted after reset");
  // ==================================================
  // covers
  c_sleep_wake: cover property (mode == pdm_pkg::PDM_SLEEP ##1 int_exc);
  c_settle_done: cover property (mode == pdm_pkg::PDM_SETTLE ##1 mode == pdm_pkg::PDM_RUN);
  c_hw_leave: cover property (mode == pdm_pkg::PDM_HWSTBY ##1 mode == pdm_pkg::PDM_RESET);
endmodule : pdm_props

// ---- pdm_regs.svh ----
/*
  constants of the power-down mode controller: register offsets, field positions,
  reset values and timing figures. assumes a 100 MHz system clock.
*/
// Notes on behaviour
// - nonzero divider select: divided cpu clock after bus cycle
// - transfer controller divided unless full-speed bit set
// - bus states counted in master clock ticks
// - zero divider select returns to high speed
// - sleep when standby select clear; speed kept
// - software standby when standby set, prescaler clear
// - reset pin or watchdog overflow enters reset
// - sleep halts cpu, peripherals keep running
// - accepted interrupt ends sleep; masked ones ignored
// - reset pin cancels sleep; released after settling
// - software standby stops cpu, peripherals, oscillator
// - standby wake: restart oscillator, settle, then interrupt
// - line wakes standby only when enabled, unmasked
// - reset in standby restarts clock for whole chip
// - standby pin low: hardware standby, ports float
// - ram enable cleared first; mode pins frozen
// - standby pin rises, reset released after settling
// - halt bit stops module at bus cycle end
// - after reset all modules but transfer controller halted
// - halted module registers are not accessible
// - transfer controller request beats its halt write
// - subclock enable set two cycles before power-down
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH
// ==================================================
// device register offsets
`define PDM_OFS_STANDBY_PIN_N_CTRL 8'h00
`define PDM_OFS_HALT 8'h04
`define PDM_OFS_IRQ_EN 8'h08
`define PDM_OFS_STATUS 8'h0c
// host register offsets
`define PDM_OFS_HCTRL 8'h10
`define PDM_OFS_HMODE 8'h14
`define PDM_OFS_HSTAT 8'h18
`define PDM_DEV_TOP 8'h0c
// ==================================================
// standby_control_reg fields
`define PDM_F_DIV_LO 0
`define PDM_F_DIV_HI 2
`define PDM_F_FULL 3
`define PDM_F_SOFTWARE_STANDBY_SELECT 4
`define PDM_F_STS_LO 5
`define PDM_F_STS_HI 7
`define PDM_F_PSS 8
`define PDM_F_SUBEN 9
`define PDM_F_RAM_ENABLE_BIT 10
`define PDM_STANDBY_PIN_N_RST 16'h0400
`define PDM_DIV_MAX 3'h5
// host control fields
`define PDM_H_RESET 0
`define PDM_H_STANDBY_PIN_N 1
`define PDM_H_SLEEP 2
`define PDM_H_WDT 3
`define PDM_H_SUBEN 4
`define PDM_HCTRL_RST 5'h01
// ==================================================
// timing
`define PDM_OSC_SETTLE_NS 10000
`define PDM_CLK_NS 10
`define PDM_SETTLE_CYC ((`PDM_OSC_SETTLE_NS + `PDM_CLK_NS - 1) / `PDM_CLK_NS)
`define PDM_SUB_WAIT_CYC 2
`endif

// ---- pdm_tb.sv ----
/*
  testbench of the power-down controller: host and device joined by pdm_if.
  assumes short settle parameters; drives only the host inputs and the shared reset.
*/
`timescale 1ns/100ps
module power_down_mode_control_tb;
  localparam int SB = 2;
  localparam int SC = 4;
  typedef struct packed {logic [2:0] sel; logic full; logic [15:0] cpu; logic [15:0] transfer_controller;} pdm_row_s;
  logic sys_clk_i, rst_n_i, usr_wr_i, usr_rd_i, bus_end_i, dtc_req_i, nmi_i, int_pend_i, int_mask_i;
  pdm_pkg::pdm_addr_t usr_addr_i;
  pdm_pkg::pdm_data_t usr_wdata_i, usr_rdata_o;
  logic [15:0] irq_i;
  logic [7:0] per_sel_i;
  int n_fail, compares, n, nc, nd, np;
  // 64-cycle window: every divider period divides it, so phase cannot skew counts
  pdm_row_s rows [8] = '{'{3'h0, 1'b0, 16'h40, 16'h40}, '{3'h1, 1'b0, 16'h20, 16'h20},
    '{3'h2, 1'b1, 16'h10, 16'h40}, '{3'h3, 1'b0, 16'h08, 16'h08}, '{3'h4, 1'b1, 16'h04, 16'h40},
    '{3'h5, 1'b0, 16'h02, 16'h02}, '{3'h7, 1'b0, 16'h02, 16'h02}, '{3'h0, 1'b1, 16'h40, 16'h40}};
  pdm_if #(.N(8)) lnk ();
  pdm_dev #(.N(8), .LOSE_MASK(8'he0), .SETTLE_BASE(SB)) i_pdm_dev (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .lnk(lnk));
  pdm_host #(.N(8), .SETTLE_CYC(SC)) i_pdm_host (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .usr_addr_i(usr_addr_i), .usr_wdata_i(usr_wdata_i), .usr_wr_i(usr_wr_i), .usr_rd_i(usr_rd_i),
    .usr_rdata_o(usr_rdata_o), .bus_end_i(bus_end_i), .dtc_req_i(dtc_req_i), .nmi_i(nmi_i),
    .irq_i(irq_i), .int_pend_i(int_pend_i), .int_mask_i(int_mask_i), .per_sel_i(per_sel_i),
    .mode_pins_o(), .lnk(lnk));
  pdm_props #(.N(8)) i_pdm_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reset_pin_n(lnk.reset_pin_n), .standby_pin_n(lnk.standby_pin_n), .wdt_ovf(lnk.wdt_ovf),
    .nmi(lnk.nmi), .int_pend(lnk.int_pend), .int_mask(lnk.int_mask), .per_sel(lnk.per_sel),
    .mstop(lnk.mstop), .per_acc_en(lnk.per_acc_en), .cpu_tick(lnk.cpu_tick),
    .per_tick(lnk.per_tick), .osc_run(lnk.osc_run), .chip_reset(lnk.chip_reset),
    .io_hiz(lnk.io_hiz), .int_exc(lnk.int_exc), .rst_exc(lnk.rst_exc), .mode(lnk.mode));
  // ==================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input pdm_pkg::pdm_addr_t a, input pdm_pkg::pdm_data_t d);
    @(posedge sys_clk_i);
    usr_wr_i <= 1'b1;
    usr_addr_i <= a;
    usr_wdata_i <= d;
    @(posedge sys_clk_i);
    usr_wr_i <= 1'b0;
  endtask : wr
  task automatic rd_chk(input pdm_pkg::pdm_addr_t a, input pdm_pkg::pdm_data_t e);
    @(posedge sys_clk_i);
    usr_rd_i <= 1'b1;
    usr_addr_i <= a;
    @(posedge sys_clk_i);
    usr_rd_i <= 1'b0;
    #1;
    chk(usr_rdata_o, e);
  endtask : rd_chk
  task automatic mode_is(input pdm_pkg::pdm_mode_e e);
    #1;
    for (int i = 0; i < 60 && lnk.mode !== e; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk({10'h0, lnk.mode}, {10'h0, e});
  endtask : mode_is
  task automatic cnt;
    nc = 0;
    nd = 0;
    np = 0;
    repeat (64) begin
      @(posedge sys_clk_i);
      #1;
      nc += int'(lnk.cpu_tick === 1'b1);
      nd += int'(lnk.dtc_tick === 1'b1);
      np += int'(lnk.per_tick === 1'b1);
    end
  endtask : cnt
  task automatic summarize;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // ==================================================
  // clock, watchdog, tests
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    summarize();
  end
  initial begin
    {rst_n_i, usr_wr_i, usr_rd_i, dtc_req_i, nmi_i, int_pend_i, int_mask_i} = '0;
    {usr_addr_i, usr_wdata_i, irq_i} = '0;
    bus_end_i = 1'b1;
    per_sel_i = 8'hff;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wr(8'h10, 16'h0000);
    mode_is(pdm_pkg::PDM_RUN);
    rd_chk(8'h00, 16'h0400);
    rd_chk(8'h04, 16'h00fe);
    rd_chk(8'h08, 16'h0000);
    rd_chk(8'h20, 16'h0000);
    rd_chk(8'h0c, 16'h0002);
    chk({8'h0, lnk.per_acc_en}, 16'h0001);
    chk({8'h0, lnk.mclear}, 16'h00e0);
    chk({14'h0, lnk.sub_en, lnk.ram_en}, 16'h0001);
    foreach (rows[i]) begin
      wr(8'h00, 16'h0400 | {12'h0, rows[i].full, rows[i].sel});
      repeat (4) @(posedge sys_clk_i);
      cnt();
      chk(16'(nc), rows[i].cpu);
      chk(16'(nd), rows[i].transfer_controller);
      chk(16'(np), 16'h0040);
    end
    // sleep at /4, masked interrupt must not wake
    wr(8'h00, 16'h0402);
    int_pend_i <= 1'b1;
    int_mask_i <= 1'b1;
    wr(8'h10, 16'h0004);
    mode_is(pdm_pkg::PDM_SLEEP);
    repeat (5) @(posedge sys_clk_i);
    chk({10'h0, lnk.mode}, {10'h0, pdm_pkg::PDM_SLEEP});
    nmi_i <= 1'b1;
    @(posedge sys_clk_i);
    nmi_i <= 1'b0;
    mode_is(pdm_pkg::PDM_RUN);
    int_pend_i <= 1'b0;
    int_mask_i <= 1'b0;
    cnt();
    chk(16'(nc), 16'h0010);
    // software standby at /8, settle select 1
    wr(8'h08, 16'h0001);
    wr(8'h00, 16'h0433);
    wr(8'h10, 16'h0004);
    mode_is(pdm_pkg::PDM_SWSTBY);
    irq_i <= 16'h0002;
    int_mask_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    irq_i <= 16'h0001;
    repeat (5) @(posedge sys_clk_i);
    chk({10'h0, lnk.mode}, {10'h0, pdm_pkg::PDM_SWSTBY});
    int_mask_i <= 1'b0;
    n = 0;
    for (int i = 0; i < 40 && lnk.mode !== pdm_pkg::PDM_RUN; i++) begin
      @(posedge sys_clk_i);
      #1;
      n += int'(lnk.mode === pdm_pkg::PDM_SETTLE);
    end
    chk(16'(n), 16'(SB << 1));
    irq_i <= 16'h0000;
    cnt();
    chk(16'(nc), 16'h0008);
    wr(8'h00, 16'h0513);
    wr(8'h10, 16'h0004);
    repeat (3) @(posedge sys_clk_i);
    chk({10'h0, lnk.mode}, {10'h0, pdm_pkg::PDM_RUN});
    // nonmaskable line also wakes software standby
    wr(8'h00, 16'h0433);
    wr(8'h10, 16'h0004);
    mode_is(pdm_pkg::PDM_SWSTBY);
    nmi_i <= 1'b1;
    @(posedge sys_clk_i);
    nmi_i <= 1'b0;
    mode_is(pdm_pkg::PDM_SETTLE);
    mode_is(pdm_pkg::PDM_RUN);
    // module halt, then the transfer controller conflict
    wr(8'h00, 16'h0400);
    // subclock enable: sleep refused until the subclock has loaded two cycles
    wr(8'h10, 16'h0010);
    wr(8'h10, 16'h0014);
    repeat (3) @(posedge sys_clk_i);
    chk({10'h0, lnk.mode}, {10'h0, pdm_pkg::PDM_RUN});
    wr(8'h10, 16'h0014);
    mode_is(pdm_pkg::PDM_SLEEP);
    nmi_i <= 1'b1;
    @(posedge sys_clk_i);
    nmi_i <= 1'b0;
    mode_is(pdm_pkg::PDM_RUN);
    wr(8'h04, 16'h0000);
    repeat (2) @(posedge sys_clk_i);
    chk({8'h0, lnk.per_acc_en}, 16'h00ff);
    chk({8'h0, lnk.mclear}, 16'h0000);
    dtc_req_i <= 1'b1;
    wr(8'h04, 16'h0001);
    dtc_req_i <= 1'b0;
    rd_chk(8'h04, 16'h0000);
    wr(8'h04, 16'h0001);
    repeat (2) @(posedge sys_clk_i);
    cnt();
    chk(16'(nd), 16'h0000);
    // both pins low: standby pin wins, mode pins frozen
    wr(8'h10, 16'h0003);
    mode_is(pdm_pkg::PDM_HWSTBY);
    chk({15'h0, lnk.io_hiz}, 16'h0001);
    wr(8'h14, 16'h0003);
    rd_chk(8'h14, 16'h0000);
    wr(8'h10, 16'h0001);
    mode_is(pdm_pkg::PDM_RESET);
    wr(8'h10, 16'h0000);
    mode_is(pdm_pkg::PDM_RUN);
    rd_chk(8'h04, 16'h00fe);
    // watchdog overflow cancels medium speed
    wr(8'h00, 16'h0402);
    wr(8'h10, 16'h0008);
    mode_is(pdm_pkg::PDM_RESET);
    mode_is(pdm_pkg::PDM_RUN);
    rd_chk(8'h00, 16'h0400);
    cnt();
    chk(16'(nc), 16'h0040);
    summarize();
  end
endmodule : power_down_mode_control_tb
